// file: src/bus_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_cmd_defines.svh"
module bus_timeout (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic bclk_rise,
	input  wire logic mack_n,
	input  wire logic mreq_n,
	input  wire logic cmd_n,
	input  wire logic other_request,
	input  wire logic cpu_owns,
	output logic      timeout
);

	logic       mack_n_prev_reg;
	logic       armed_reg;
	logic [6:0] mack_cnt_reg;
	logic [8:0] cmd_cnt_reg;
	logic       mack_expire;
	logic       cmd_expire;

	assign mack_expire = armed_reg && bclk_rise &&
		(mack_cnt_reg == 7'(`MACK_TIMEOUT_BCLKS - 1));
	assign cmd_expire = bclk_rise && !cmd_n && other_request &&
		(cmd_cnt_reg == 9'(`CMD_TIMEOUT_BCLKS));

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			mack_n_prev_reg <= 1'b1;
		else
			mack_n_prev_reg <= mack_n;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			armed_reg <= 1'b0;
			mack_cnt_reg <= 7'h00;
		end
		else if (mack_n && !mack_n_prev_reg)
		begin
			armed_reg <= 1'b1;
			mack_cnt_reg <= 7'h00;
		end
		else if (!mack_n || mack_expire)
			armed_reg <= 1'b0;
		else if (armed_reg && bclk_rise)
			mack_cnt_reg <= mack_cnt_reg + 7'h01;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cmd_cnt_reg <= 9'h000;
		else if (cmd_n || cpu_owns)
			cmd_cnt_reg <= 9'h000;
		else if (bclk_rise && other_request && !cmd_expire)
			cmd_cnt_reg <= cmd_cnt_reg + 9'h001;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			timeout <= 1'b0;
		else
			timeout <= !cpu_owns &&
				((mack_expire && !mreq_n) || cmd_expire);
	end

endmodule
`default_nettype wire

// file: src/dma_cmd_defines.svh
// How it works
// - Host has separate byte pointers for channel groups 0-3 and 4-7.
// - Host write to 0Ch clears low pointer; 0D8h clears high pointer.
// - One shared pointer serves EISA masters, cleared by their 0Ch/0D8h write.
// - Master clear acts like reset: clears state, sets masks, goes idle.
// - Master clear at 0Dh hits channels 0-3, at 0DAh channels 4-7.
// - Write to 0Eh or 0DCh clears all four masks of that group.
// - Plain terminal event sets terminal count, sets mask, clears request.
// - Auto reload event sets terminal count, clears request, reloads current.
// - Chain with base loaded only reloads current registers on terminal event.
// - Stop limit sets the mask and nothing else.
// - Bus timeout raises NMI and drives the expansion reset.
// - No bus timeout while the system CPU owns the bus.
// - 64 bus clocks after grant removal, still requesting means timeout.
// - No new grant until the cycle in progress status goes inactive.
// - Command active over 256 bus clocks means timeout.
// - Command counter runs only while another source requests the bus.
// - Non-compatible DMA with rival request runs 4 us, then releases.
// - Preemption timer idle for compatible timing and 16-bit cascade masters.
// - Preempted block mode channel gets rearbitration flag; reset drive clears.
// - Read-only latch at 0464h shows last granted slot as a zero bit.
// - Slot 7 and 8 bits always read high; 0465h is not decoded.
`ifndef DMA_CMD_DEFINES_SVH
`define DMA_CMD_DEFINES_SVH

`define CLR_BYTE_PTR_LO_ADDR 16'h000c
`define MASTER_CLR_LO_ADDR   16'h000d
`define CLR_MASKS_LO_ADDR    16'h000e
`define CLR_BYTE_PTR_HI_ADDR 16'h00d8
`define MASTER_CLR_HI_ADDR   16'h00da
`define CLR_MASKS_HI_ADDR    16'h00dc
`define LAST_MASTER_ADDR     16'h0464

`define LAST_MASTER_RESET    8'hff
`define LAST_MASTER_FIXED    8'hc0
`define MASK_RESET           1'b1
`define BYTE_PTR_RESET       1'b0

`define REF_CLK_PERIOD_NS    25
`define PREEMPT_TIME_NS      4000
`define PREEMPT_CYCLES       (`PREEMPT_TIME_NS / `REF_CLK_PERIOD_NS)
`define MACK_TIMEOUT_BCLKS   64
`define CMD_TIMEOUT_BCLKS    256

`endif

// file: src/dma_cmd_pkg.sv
`default_nettype none
package dma_cmd_pkg;

	typedef struct packed {
		logic word_count_expired;
		logic end_of_process;
		logic stop_limit;
		logic auto_reload;
		logic chain_loaded;
	} chan_evt_t;

	typedef struct packed {
		logic bclk;
		logic mack_n;
		logic mreq_n;
		logic cycle_in_progress_n;
		logic cmd_n;
	} bus_pins_t;

	typedef enum logic [2:0] {
		PRE_IDLE    = 3'b001,
		PRE_TIMING  = 3'b010,
		PRE_RELEASE = 3'b100
	} preempt_state_t;

endpackage
`default_nettype wire

// file: src/dma_command_and_bus_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_cmd_defines.svh"
module dma_command_and_bus_timeout (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire logic [15:0]                 io_addr,
	input  wire logic                        io_wr,
	input  wire logic                        io_rd,
	input  wire logic                        eisa_master_owns,
	input  wire logic [1:0]                  byte_access,
	input  wire logic [7:0]                  sw_req_set,
	input  wire dma_cmd_pkg::chan_evt_t [7:0] chan_evt,
	input  wire dma_cmd_pkg::bus_pins_t      bus_pins,
	input  wire logic                        other_request,
	input  wire logic                        cpu_owns,
	input  wire logic                        dma_owns,
	input  wire logic                        dma_compatible_timing,
	input  wire logic                        dma_isa16_cascade,
	input  wire logic                        dma_block_mode,
	input  wire logic [2:0]                  dma_channel,
	input  wire logic                        dma_cycle_done,
	input  wire logic                        slot_grant,
	input  wire logic [2:0]                  slot_grant_id,
	output logic [7:0]                       io_rdata,
	output logic                             byte_ptr_lo,
	output logic                             byte_ptr_hi,
	output logic                             byte_ptr_eisa,
	output logic [1:0]                       controller_idle,
	output logic [7:0]                       tc_status,
	output logic [7:0]                       mask,
	output logic [7:0]                       sw_request,
	output logic [7:0]                       reload_current,
	output logic                             nmi,
	output logic                             expansion_reset_drive,
	output logic                             grant_allowed,
	output logic                             dack_release,
	output logic [7:0]                       rearb_flag
);

	dma_cmd_pkg::bus_pins_t       sync1_reg;
	dma_cmd_pkg::bus_pins_t       sync2_reg;
	logic                         bclk_prev_reg;
	logic                         bclk_rise;
	logic                         timeout;
	logic                         wr_bp_lo;
	logic                         wr_bp_hi;
	logic [1:0]                   master_clr;
	logic [1:0]                   clr_masks;
	logic [7:0]                   last_master_reg;
	logic [7:0]                   last_master_next;
	logic [7:0]                   preempt_cnt_reg;
	logic                         preempt_run;
	dma_cmd_pkg::preempt_state_t  pre_state_reg;

	// Every pin passes two flops before any logic looks at it.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// Idle pin levels, so no false bus clock edge follows reset.
			sync1_reg <= 5'h0f;
			sync2_reg <= 5'h0f;
			bclk_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= bus_pins;
			sync2_reg <= sync1_reg;
			bclk_prev_reg <= sync2_reg.bclk;
		end
	end

	assign bclk_rise = sync2_reg.bclk & ~bclk_prev_reg;

	assign wr_bp_lo = io_wr && (io_addr == `CLR_BYTE_PTR_LO_ADDR);
	assign wr_bp_hi = io_wr && (io_addr == `CLR_BYTE_PTR_HI_ADDR);
	assign master_clr[0] = io_wr && (io_addr == `MASTER_CLR_LO_ADDR);
	assign master_clr[1] = io_wr && (io_addr == `MASTER_CLR_HI_ADDR);
	assign clr_masks[0] = io_wr && (io_addr == `CLR_MASKS_LO_ADDR);
	assign clr_masks[1] = io_wr && (io_addr == `CLR_MASKS_HI_ADDR);

	// The host pointers freeze while an EISA master programs, except that a
	// master clear still clears them, so the host sequence resumes in step
	// once it gets the bus back.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			byte_ptr_lo <= `BYTE_PTR_RESET;
		else if ((wr_bp_lo && !eisa_master_owns) || master_clr[0])
			byte_ptr_lo <= 1'b0;
		else if (byte_access[0] && !eisa_master_owns)
			byte_ptr_lo <= ~byte_ptr_lo;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			byte_ptr_hi <= `BYTE_PTR_RESET;
		else if ((wr_bp_hi && !eisa_master_owns) || master_clr[1])
			byte_ptr_hi <= 1'b0;
		else if (byte_access[1] && !eisa_master_owns)
			byte_ptr_hi <= ~byte_ptr_hi;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			byte_ptr_eisa <= `BYTE_PTR_RESET;
		else if ((wr_bp_lo || wr_bp_hi) && eisa_master_owns)
			byte_ptr_eisa <= 1'b0;
		else if ((|byte_access) && eisa_master_owns)
			byte_ptr_eisa <= ~byte_ptr_eisa;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			controller_idle <= 2'h0;
		else
			controller_idle <= master_clr;
	end

	genvar ch;
	generate
		for (ch = 0; ch < 8; ch++)
		begin : g_chan
			tc_channel u_chan (
				.ref_clk        (ref_clk),
				.nrst           (nrst),
				.group_clear    (master_clr[ch / 4]),
				.clear_mask     (clr_masks[ch / 4]),
				.sw_req_set     (sw_req_set[ch]),
				.evt            (chan_evt[ch]),
				.tc_status      (tc_status[ch]),
				.mask           (mask[ch]),
				.sw_request     (sw_request[ch]),
				.reload_current (reload_current[ch])
			);
		end
	endgenerate

	bus_timeout u_timeout (
		.ref_clk       (ref_clk),
		.nrst          (nrst),
		.bclk_rise     (bclk_rise),
		.mack_n        (sync2_reg.mack_n),
		.mreq_n        (sync2_reg.mreq_n),
		.cmd_n         (sync2_reg.cmd_n),
		.other_request (other_request),
		.cpu_owns      (cpu_owns),
		.timeout       (timeout)
	);

	// Both outputs hold until hardware reset; the NMI handler needs them
	// to stay visible after the offending master has gone.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			nmi <= 1'b0;
			expansion_reset_drive <= 1'b0;
		end
		else if (timeout)
		begin
			nmi <= 1'b1;
			expansion_reset_drive <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			grant_allowed <= 1'b0;
		else
			grant_allowed <= sync2_reg.cycle_in_progress_n;
	end

	assign preempt_run = dma_owns && other_request &&
		!dma_compatible_timing && !dma_isa16_cascade;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pre_state_reg <= dma_cmd_pkg::PRE_IDLE;
			preempt_cnt_reg <= 8'h00;
		end
		else
		begin
			case (pre_state_reg)
				dma_cmd_pkg::PRE_IDLE:
				begin
					preempt_cnt_reg <= 8'h00;
					if (preempt_run)
						pre_state_reg <= dma_cmd_pkg::PRE_TIMING;
				end
				dma_cmd_pkg::PRE_TIMING:
				begin
					if (!preempt_run)
						pre_state_reg <= dma_cmd_pkg::PRE_IDLE;
					else if (preempt_cnt_reg ==
						8'(`PREEMPT_CYCLES - 2))
						pre_state_reg <= dma_cmd_pkg::PRE_RELEASE;
					else
						preempt_cnt_reg <= preempt_cnt_reg + 8'h01;
				end
				dma_cmd_pkg::PRE_RELEASE:
				begin
					if (dma_cycle_done || !dma_owns)
						pre_state_reg <= dma_cmd_pkg::PRE_IDLE;
				end
				default:
					pre_state_reg <= dma_cmd_pkg::PRE_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			dack_release <= 1'b0;
		else
			dack_release <= (pre_state_reg == dma_cmd_pkg::PRE_RELEASE) &&
				dma_owns && dma_cycle_done;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rearb_flag <= 8'h00;
		else if (expansion_reset_drive)
			rearb_flag <= 8'h00;
		else if ((pre_state_reg == dma_cmd_pkg::PRE_RELEASE) && dma_owns &&
			dma_cycle_done && dma_block_mode)
			rearb_flag[dma_channel] <= 1'b1;
	end

	always_comb
	begin
		last_master_next = `LAST_MASTER_RESET;
		last_master_next[slot_grant_id] = 1'b0;
		last_master_next = last_master_next | `LAST_MASTER_FIXED;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			last_master_reg <= `LAST_MASTER_RESET;
		else if (slot_grant)
			last_master_reg <= last_master_next;
	end

	// Writes to the latch are ignored; every other port reads back as zero.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			io_rdata <= 8'h00;
		else if (io_rd && (io_addr == `LAST_MASTER_ADDR))
			io_rdata <= last_master_reg;
		else
			io_rdata <= 8'h00;
	end

endmodule
`default_nettype wire

// file: src/tc_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_cmd_defines.svh"
module tc_channel (
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic                  group_clear,
	input  wire logic                  clear_mask,
	input  wire logic                  sw_req_set,
	input  wire dma_cmd_pkg::chan_evt_t evt,
	output logic                       tc_status,
	output logic                       mask,
	output logic                       sw_request,
	output logic                       reload_current
);

	logic term;
	logic use_chain;
	logic plain;

	assign term = evt.word_count_expired | evt.end_of_process;
	// Auto reload takes precedence; chaining only counts without it.
	assign use_chain = ~evt.auto_reload & evt.chain_loaded;
	assign plain = ~evt.auto_reload & ~evt.chain_loaded;

	// A terminal event in the same cycle as a master clear still counts.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			tc_status <= 1'b0;
		else if (term && !use_chain)
			tc_status <= 1'b1;
		else if (group_clear)
			tc_status <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			mask <= `MASK_RESET;
		else if ((term && plain) || evt.stop_limit || group_clear)
			mask <= 1'b1;
		else if (clear_mask)
			mask <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			sw_request <= 1'b0;
		else if (sw_req_set)
			sw_request <= 1'b1;
		else if ((term && !use_chain) || group_clear)
			sw_request <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			reload_current <= 1'b0;
		else
			reload_current <= term & ~plain;
	end

endmodule
`default_nettype wire

// file: tb/dma_command_and_bus_timeout_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dma_cmd_checker (
	input wire logic                         ref_clk,
	input wire logic                         nrst,
	input wire logic [15:0]                  io_addr,
	input wire logic                         io_wr,
	input wire logic                         io_rd,
	input wire logic                         eisa_master_owns,
	input wire logic [1:0]                   byte_access,
	input wire dma_cmd_pkg::chan_evt_t [7:0] chan_evt,
	input wire dma_cmd_pkg::bus_pins_t       bus_pins,
	input wire logic                         cpu_owns,
	input wire logic                         dma_owns,
	input wire logic                         dma_compatible_timing,
	input wire logic                         dma_isa16_cascade,
	input wire logic [7:0]                   io_rdata,
	input wire logic                         byte_ptr_lo,
	input wire logic                         byte_ptr_eisa,
	input wire logic [1:0]                   controller_idle,
	input wire logic [7:0]                   tc_status,
	input wire logic [7:0]                   mask,
	input wire logic                         nmi,
	input wire logic                         expansion_reset_drive,
	input wire logic                         grant_allowed,
	input wire logic                         dack_release
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_mclr;
		io_wr && io_addr == 16'h000d |=> controller_idle == 2'h1
			&& mask[3:0] == 4'hf;
	endproperty
	a_mclr: assert property (p_mclr)
		else $error("low group master clear missed");
	property p_cmask;
		io_wr && io_addr == 16'h000e && chan_evt == '0 |=> mask[3:0] == 4'h0;
	endproperty
	a_cmask: assert property (p_cmask)
		else $error("low group masks not cleared");
	property p_tog;
		byte_access == 2'h1 && !eisa_master_owns && !io_wr
			|=> byte_ptr_lo != $past(byte_ptr_lo);
	endproperty
	a_tog: assert property (p_tog)
		else $error("low byte pointer did not toggle");
	property p_eptr;
		io_wr && eisa_master_owns &&
			(io_addr == 16'h000c || io_addr == 16'h00d8)
			|=> !byte_ptr_eisa && $stable(byte_ptr_lo);
	endproperty
	a_eptr: assert property (p_eptr)
		else $error("shared byte pointer clear wrong");
	property p_plain;
		chan_evt[0] == 5'h10 |=> tc_status[0] && mask[0];
	endproperty
	a_plain: assert property (p_plain)
		else $error("plain terminal event missed");
	property p_stop;
		chan_evt[3] == 5'h04 && !io_wr |=> mask[3] && $stable(tc_status[3]);
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop limit effect wrong");
	property p_nmi;
		nmi |-> expansion_reset_drive ##1 nmi;
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("nmi without reset drive");
	property p_cpu;
		cpu_owns [*3] |=> !$rose(nmi);
	endproperty
	a_cpu: assert property (p_cpu)
		else $error("timeout while cpu owns bus");
	property p_grant;
		grant_allowed |-> $past(bus_pins.cycle_in_progress_n, 3);
	endproperty
	a_grant: assert property (p_grant)
		else $error("grant allowed during bus cycle");
	property p_rsvd;
		io_rd && io_addr == 16'h0465 |=> io_rdata == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved port answered");
	property p_pre;
		dack_release |-> $past(dma_owns) && !$past(dma_compatible_timing)
			&& !$past(dma_isa16_cascade);
	endproperty
	a_pre: assert property (p_pre)
		else $error("release without preemption");

	c_dack: cover property (dack_release);
	c_nmi: cover property ($rose(nmi));
	c_idle: cover property (controller_idle == 2'h2);
endmodule
`default_nettype wire

// file: tb/dma_command_and_bus_timeout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_command_and_bus_timeout_tb;
	logic        ref_clk = 1'h0;
	logic        nrst = 1'h0;
	logic [15:0] io_addr = 16'h0000;
	logic        io_wr = 1'h0, io_rd = 1'h0, eisa_master_owns = 1'h0;
	logic [1:0]  byte_access = 2'h0;
	logic [7:0]  sw_req_set = 8'h00;
	logic        other_request = 1'h0, cpu_owns = 1'h0, dma_owns = 1'h0;
	logic        dma_compatible_timing = 1'h0, dma_isa16_cascade = 1'h0;
	logic        dma_block_mode = 1'h0, dma_cycle_done = 1'h0;
	logic        slot_grant = 1'h0, mreq = 1'h0, mack = 1'h0;
	logic        cyc = 1'h0, cmd = 1'h0;
	logic [2:0]  dma_channel = 3'h0, slot_grant_id = 3'h0;
	logic [7:0]  io_rdata, tc_status, mask, sw_request;
	logic [7:0]  reload_current, rearb_flag;
	logic [1:0]  controller_idle;
	logic        byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa, nmi;
	logic        expansion_reset_drive, grant_allowed, dack_release;
	int          mismatches = 0, num_checks = 0, n;
	dma_cmd_pkg::chan_evt_t [7:0] chan_evt = '0;
	dma_cmd_pkg::bus_pins_t       bus_pins;

	always #12.5 ref_clk = ~ref_clk;

	eisa_bus_model bus (.req_bus(mreq), .ack_bus(mack), .in_cycle(cyc),
		.cmd_on(cmd), .pins(bus_pins));

	dma_command_and_bus_timeout uut (.ref_clk, .nrst, .io_addr, .io_wr,
		.io_rd, .eisa_master_owns, .byte_access, .sw_req_set, .chan_evt,
		.bus_pins, .other_request, .cpu_owns, .dma_owns,
		.dma_compatible_timing, .dma_isa16_cascade, .dma_block_mode,
		.dma_channel, .dma_cycle_done, .slot_grant, .slot_grant_id,
		.io_rdata, .byte_ptr_lo, .byte_ptr_hi, .byte_ptr_eisa,
		.controller_idle, .tc_status, .mask, .sw_request, .reload_current,
		.nmi, .expansion_reset_drive, .grant_allowed, .dack_release,
		.rearb_flag);

	task automatic test_done;
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(negedge ref_clk);
	endtask

	task automatic do_reset;
		nrst = 1'h0;
		tick(5);
		nrst = 1'h1;
	endtask

	// The leading cycle keeps a strobe from falling and rising at once.
	task automatic wr(input logic [15:0] a);
		tick(1);
		io_addr = a;
		io_wr = 1'h1;
		tick(1);
		io_wr = 1'h0;
	endtask

	task automatic rd(input logic [15:0] a);
		tick(1);
		io_addr = a;
		io_rd = 1'h1;
		tick(1);
		io_rd = 1'h0;
	endtask

	// The extra cycle keeps two pulses from landing in one time step.
	task automatic ba(input logic [1:0] v);
		byte_access = v;
		tick(1);
		byte_access = 2'h0;
		tick(1);
	endtask

	task automatic ev(input int c, input dma_cmd_pkg::chan_evt_t e);
		tick(1);
		chan_evt[c] = e;
		tick(1);
		chan_evt[c] = 5'h00;
	endtask

	task automatic fin;
		dma_cycle_done = 1'h1;
		tick(1);
		dma_cycle_done = 1'h0;
	endtask

	task automatic wait_nmi(input int lim);
		n = 0;
		while (nmi !== 1'h1 && n < lim)
		begin
			tick(1);
			n++;
		end
		if (n >= lim)
		begin
			mismatches++;
			test_done();
		end
	endtask

	initial
	begin
		do_reset();
		chk(16'(mask), 16'h00ff);
		rd(16'h0464);
		chk(16'(io_rdata), 16'h00ff);
		wr(16'h000c);
		wr(16'h00d8);
		ba(2'h1);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h4);
		ba(2'h3);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h2);
		wr(16'h00d8);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h0);
		ba(2'h1);
		eisa_master_owns = 1'h1;
		ba(2'h2);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h5);
		wr(16'h000c);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h4);
		eisa_master_owns = 1'h0;
		wr(16'h000c);
		chk(16'({byte_ptr_lo, byte_ptr_hi, byte_ptr_eisa}), 16'h0);
		wr(16'h000e);
		chk(16'(mask), 16'h00f0);
		wr(16'h00dc);
		chk(16'(mask), 16'h0000);
		sw_req_set = 8'hff;
		tick(1);
		sw_req_set = 8'h00;
		ev(0, 5'h10);
		chk(16'(reload_current), 16'h0000);
		ev(1, 5'h0a);
		chk(16'(reload_current), 16'h0002);
		ev(2, 5'h11);
		chk(16'(reload_current), 16'h0004);
		ev(3, 5'h04);
		chk(16'(reload_current), 16'h0000);
		ev(5, 5'h08);
		chk({tc_status, sw_request}, 16'h23dc);
		chk(16'(mask), 16'h0029);
		wr(16'h000d);
		chk({6'h00, controller_idle, mask}, 16'h012f);
		chk({tc_status, sw_request}, 16'h20d0);
		wr(16'h00da);
		chk({6'h00, controller_idle, mask}, 16'h02ff);
		chk({tc_status, sw_request}, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			slot_grant = 1'h1;
			slot_grant_id = 3'(i);
			tick(1);
			slot_grant = 1'h0;
			rd(16'h0464);
			chk(16'(io_rdata), {8'h00, ~(8'h01 << i) | 8'hc0});
		end
		rd(16'h0465);
		chk(16'(io_rdata), 16'h0000);
		dma_owns = 1'h1;
		other_request = 1'h1;
		dma_compatible_timing = 1'h1;
		dma_block_mode = 1'h1;
		dma_channel = 3'h5;
		tick(200);
		fin();
		chk({7'h00, dack_release, rearb_flag}, 16'h0000);
		dma_compatible_timing = 1'h0;
		dma_isa16_cascade = 1'h1;
		tick(200);
		fin();
		chk({7'h00, dack_release, rearb_flag}, 16'h0000);
		dma_isa16_cascade = 1'h0;
		tick(170);
		fin();
		chk({7'h00, dack_release, rearb_flag}, 16'h0120);
		dma_owns = 1'h0;
		other_request = 1'h0;
		cyc = 1'h1;
		tick(40);
		chk(16'(grant_allowed), 16'h0000);
		cyc = 1'h0;
		tick(40);
		chk(16'(grant_allowed), 16'h0001);
		cpu_owns = 1'h1;
		mreq = 1'h1;
		mack = 1'h1;
		tick(40);
		mack = 1'h0;
		tick(450);
		chk(16'(nmi), 16'h0000);
		cpu_owns = 1'h0;
		mack = 1'h1;
		tick(40);
		mack = 1'h0;
		wait_nmi(500);
		chk(16'(n >= 290 && n <= 330), 16'h0001);
		chk({14'h0000, nmi, expansion_reset_drive}, 16'h0003);
		tick(1);
		chk(16'(rearb_flag), 16'h0000);
		mreq = 1'h0;
		do_reset();
		cmd = 1'h1;
		tick(1600);
		chk(16'(nmi), 16'h0000);
		other_request = 1'h1;
		wait_nmi(1400);
		chk(16'(n > 1200), 16'h0001);
		test_done();
	end
endmodule

bind dma_command_and_bus_timeout dma_cmd_checker chk_i (.ref_clk, .nrst,
	.io_addr, .io_wr, .io_rd, .eisa_master_owns, .byte_access, .chan_evt,
	.bus_pins, .cpu_owns, .dma_owns, .dma_compatible_timing,
	.dma_isa16_cascade, .io_rdata, .byte_ptr_lo, .byte_ptr_eisa,
	.controller_idle, .tc_status, .mask, .nmi, .expansion_reset_drive,
	.grant_allowed, .dack_release);
`default_nettype wire

// file: tb/eisa_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module eisa_bus_model (
	input  wire logic                  req_bus,
	input  wire logic                  ack_bus,
	input  wire logic                  in_cycle,
	input  wire logic                  cmd_on,
	output var dma_cmd_pkg::bus_pins_t pins
);
	// The bus clock runs free; master lines move on its falling edge only,
	// so a rising edge never meets a line in motion.
	initial
	begin
		pins = 5'h0f;
		forever
		begin
			#60 pins.bclk = 1'h1;
			#60 pins.bclk = 1'h0;
			pins.mack_n = ~ack_bus;
			pins.mreq_n = ~req_bus;
			pins.cycle_in_progress_n = ~in_cycle;
			pins.cmd_n = ~cmd_on;
		end
	end
endmodule
`default_nettype wire
